// >>> core/tep_core.sv
// core: two-wire serial eeprom with page write and write protection
// Functional notes
// - byte write takes word address, one data byte; stop starts write.
// - during the write cycle all bus inputs are ignored, no answer.
// - blocked writes are still acknowledged and still take a write cycle.
// - page write sends up to sixteen data bytes before the stop.
// - each page byte is acknowledged; the stop starts the write.
// - each write byte bumps only the low four address bits.
// - more than sixteen bytes wrap and overwrite earlier page bytes.
// - address polled during a write cycle is answered only when done.
// - programmed protection locks 00h to 7Fh; the pin locks everything.
// - type 0110 write with pin low programs protection after stop.
// - once programmed, type 0110 addresses get no acknowledge.
// - the protection bit never clears, not even through reset.
// - protect pin high blocks every array write.
// - protect pin high: 0110 write acknowledged, protection unchanged.
// - pin low: programmed allows 80h to FFh only, else all.
// - 0110 read acknowledged with dummy data only when unprogrammed.
// - address counter holds last accessed address plus one; writes wrap in the page.
// - read address wraps from the last byte to the first.
// - current read sends the byte at the counter after the ack.
// - controller ack fetches the next byte; no ack ends the read.
// - direction bit one means read; array reads are acked whatever the protection.
// - chip select bits must match the straps or no acknowledge.
// - bytes are eight bits plus an ack slot; receiver pulls low.
`default_nettype none
module tep_core
    import tep_pkg::*;
#(
    parameter int unsigned WR_CYCLES = WR_CYCLE_CNT
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic link_clk_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic write_protect_i,
    input wire logic [2:0] chip_select_straps_i,
    output logic write_busy_o
);
    localparam int CNT_W = $clog2(WR_CYCLES + 1);

    function automatic logic [7:0] page_inc(input logic [7:0] a);
        page_inc = {a[7:4], a[3:0] + 4'h1};
    endfunction : page_inc

    function automatic logic wr_allowed(input logic [7:0] a,
                                        input logic wp,
                                        input logic prot);
        wr_allowed = ~wp & ~(prot & ~a[7]);
    endfunction : wr_allowed

    // =====================================================================
    // link domain: synchronisers
    // =====================================================================
    logic [1:0] lrst_q;
    logic [2:0] scl_q;
    logic [2:0] sda_q;
    logic [5:0] lsy1_q;
    logic [5:0] lsy2_q;
    logic ack_p_q;
    logic busy_q;
    logic req_ack_q;
    logic prot_q = PROT_INIT;
    logic [7:0] rd_q;

    always_ff @(posedge link_clk_i) begin
        lrst_q <= {lrst_q[0], rst_n_i};
        scl_q <= {scl_q[1:0], scl_i};
        sda_q <= {sda_q[1:0], sda_i};
        lsy1_q <= {prot_q, busy_q, req_ack_q, chip_select_straps_i};
        lsy2_q <= lsy1_q;
    end

    wire lrst_n = lrst_q[1];
    wire sda_s = sda_q[1];
    wire [2:0] straps_s = lsy2_q[2:0];
    wire ack_s = lsy2_q[3];
    wire busy_s = lsy2_q[4];
    wire prot_s = lsy2_q[5];
    wire scl_rise = scl_q[1] & ~scl_q[2];
    wire scl_fall = ~scl_q[1] & scl_q[2];
    wire start_det = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
    wire stop_det = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];
    wire ack_new = ack_s ^ ack_p_q;

    // =====================================================================
    // link domain: byte engine
    // =====================================================================
    tep_state_e state_q, state_d;
    logic [3:0] bit_cnt_q, cnt_d;
    logic [7:0] shift_q, shift_d;
    logic [7:0] addr_q, addr_d;
    logic [7:0] rd_byte_q, rd_d;
    logic [2:0] straps_q;
    logic cap_q;
    logic ack_ph_q, ackph_d;
    logic sda_oe_q, oe_d;
    logic prot_cmd_q, pcmd_d;
    logic dummy_q, dummy_d;
    logic data_seen_q, seen_d;
    logic wcyc_q, wcyc_d;
    logic req_tgl_q;
    logic send;
    tep_xfer_s xfer_q, xfer_d;

    wire [3:0] dev_type = shift_q[7:4];
    wire [2:0] dev_cs = shift_q[3:1];
    wire dev_rd = shift_q[0];
    wire lblock = wcyc_q | busy_s;
    wire hit_mem = dev_type == TYPE_MEM;
    wire hit_prot = (dev_type == TYPE_PROT) & ~prot_s;
    wire dev_hit = (dev_cs == straps_q) & (hit_mem | hit_prot);
    wire byte_full = bit_cnt_q == ACK_BIT;
    wire byte_end = scl_fall & byte_full;
    wire wr_sess = (state_q == ST_WADDR) | (state_q == ST_WDATA);
    wire rx_state = (state_q == ST_DEV) | wr_sess;
    wire tx_bit = rd_byte_q[3'(4'h7 - bit_cnt_q)];
    wire is_read = xfer_q.op == OP_READ;
    wire tep_xfer_s rd_req = '{op: OP_READ, addr: addr_q, data: shift_q};

    always_comb begin
        state_d = state_q;
        cnt_d = bit_cnt_q;
        shift_d = shift_q;
        ackph_d = ack_ph_q;
        oe_d = sda_oe_q;
        addr_d = addr_q;
        pcmd_d = prot_cmd_q;
        dummy_d = dummy_q;
        seen_d = data_seen_q;
        wcyc_d = wcyc_q & ~busy_s;
        send = 1'b0;
        xfer_d = xfer_q;
        rd_d = (ack_new & is_read) ? rd_q : rd_byte_q;
        if (lblock) begin
            state_d = ST_IDLE;
            oe_d = 1'b0;
            ackph_d = 1'b0;
        end else if (stop_det) begin
            if (wr_sess & (data_seen_q | prot_cmd_q)) begin
                send = 1'b1;
                xfer_d = '{op: prot_cmd_q ? OP_COMMIT_PROT : OP_COMMIT,
                           addr: addr_q, data: shift_q};
                wcyc_d = 1'b1;
            end
            state_d = ST_IDLE;
            oe_d = 1'b0;
            ackph_d = 1'b0;
        end else if (start_det) begin
            state_d = ST_DEV;
            cnt_d = 4'h0;
            oe_d = 1'b0;
            ackph_d = 1'b0;
            seen_d = 1'b0;
        end else if (ack_ph_q) begin
            if (scl_fall) begin
                ackph_d = 1'b0;
                cnt_d = 4'h0;
                oe_d = (state_q == ST_RDATA) & ~rd_byte_q[7];
            end
        end else if (rx_state) begin
            if (scl_rise & ~byte_full) begin
                shift_d = {shift_q[6:0], sda_s};
                cnt_d = bit_cnt_q + 4'h1;
            end
            if (byte_end) begin
                ackph_d = 1'b1;
                oe_d = 1'b1;
                case (state_q)
                    ST_DEV: begin
                        if (~dev_hit) begin
                            state_d = ST_WAIT;
                            ackph_d = 1'b0;
                            oe_d = 1'b0;
                        end else if (dev_rd) begin
                            state_d = ST_RDATA;
                            dummy_d = ~hit_mem;
                            if (hit_mem) begin
                                send = 1'b1;
                                xfer_d = rd_req;
                                addr_d = addr_q + 8'h01;
                            end else begin
                                rd_d = DUMMY_READ;
                            end
                        end else begin
                            state_d = ST_WADDR;
                            pcmd_d = ~hit_mem;
                        end
                    end
                    ST_WADDR: begin
                        if (~prot_cmd_q) begin
                            addr_d = shift_q;
                        end
                        state_d = ST_WDATA;
                    end
                    default: begin
                        if (~prot_cmd_q) begin
                            send = 1'b1;
                            xfer_d = '{op: data_seen_q ? OP_LOAD
                                                       : OP_LOAD_FIRST,
                                       addr: addr_q, data: shift_q};
                            addr_d = page_inc(addr_q);
                        end
                        seen_d = 1'b1;
                    end
                endcase
            end
        end else if (state_q == ST_RDATA) begin
            if (scl_fall) begin
                oe_d = ~byte_full & ~tx_bit;
            end
            if (scl_rise & ~byte_full) begin
                cnt_d = bit_cnt_q + 4'h1;
            end else if (scl_rise & sda_s) begin
                state_d = ST_WAIT;
            end else if (scl_rise) begin
                cnt_d = 4'h0;
                if (~dummy_q) begin
                    send = 1'b1;
                    xfer_d = rd_req;
                    addr_d = addr_q + 8'h01;
                end
            end
        end
    end

    always_ff @(posedge link_clk_i) begin
        if (!lrst_n) begin
            state_q <= ST_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            addr_q <= 8'h00;
            rd_byte_q <= 8'h00;
            ack_ph_q <= 1'b0;
            sda_oe_q <= 1'b0;
            prot_cmd_q <= 1'b0;
            dummy_q <= 1'b0;
            data_seen_q <= 1'b0;
            wcyc_q <= 1'b0;
            req_tgl_q <= 1'b0;
            xfer_q <= '0;
            ack_p_q <= 1'b0;
        end else begin
            state_q <= state_d;
            bit_cnt_q <= cnt_d;
            shift_q <= shift_d;
            addr_q <= addr_d;
            rd_byte_q <= rd_d;
            ack_ph_q <= ackph_d;
            sda_oe_q <= oe_d;
            prot_cmd_q <= pcmd_d;
            dummy_q <= dummy_d;
            data_seen_q <= seen_d;
            wcyc_q <= wcyc_d;
            req_tgl_q <= req_tgl_q ^ send;
            xfer_q <= xfer_d;
            ack_p_q <= ack_s;
        end
    end

    // straps caught once after reset release
    always_ff @(posedge link_clk_i) begin
        if (!lrst_n) begin
            straps_q <= 3'h0;
            cap_q <= 1'b0;
        end else if (!cap_q) begin
            straps_q <= straps_s;
            cap_q <= 1'b1;
        end
    end

    assign sda_oe_o = sda_oe_q;

    a_busy_quiet: assert property (@(posedge link_clk_i) disable iff (!lrst_n)
        lblock |=> !sda_oe_q)
        else $error("bus driven during write cycle");
    a_prot_nack: assert property (@(posedge link_clk_i) disable iff (!lrst_n)
        byte_end && !ack_ph_q && state_q == ST_DEV && !lblock && !stop_det
        && !start_det && dev_type == TYPE_PROT && prot_s
        |=> !sda_oe_q && state_q == ST_WAIT)
        else $error("protect code acked after programming");
    a_cs_mismatch: assert property (@(posedge link_clk_i) disable iff (!lrst_n)
        byte_end && !ack_ph_q && state_q == ST_DEV && !lblock && !stop_det
        && !start_det && dev_cs != straps_q
        |=> !sda_oe_q ##1 !ack_ph_q)
        else $error("foreign chip select acked");
    a_ack_slot: assert property (@(posedge link_clk_i) disable iff (!lrst_n)
        $rose(ack_ph_q) |-> sda_oe_q)
        else $error("ack slot not pulled low");
    a_page_wrap: assert property (@(posedge link_clk_i) disable iff (!lrst_n)
        send && xfer_d.op inside {OP_LOAD, OP_LOAD_FIRST}
        |=> addr_q == page_inc($past(addr_q)))
        else $error("write address left its page");
    a_read_inc: assert property (@(posedge link_clk_i) disable iff (!lrst_n)
        send && xfer_d.op == OP_READ
        |=> addr_q == $past(addr_q) + 8'h01)
        else $error("read address not advanced by one");

    // =====================================================================
    // core domain: page buffer, write cycle, array, protection
    // =====================================================================
    logic [1:0] rsy1_q;
    logic [1:0] rsy2_q;
    logic [CNT_W-1:0] wr_cnt_q;
    logic [PAGE_BYTES-1:0] vld_q;
    logic [3:0] page_q;
    logic [7:0] buf_q [PAGE_BYTES];
    logic [7:0] mem_q [ARRAY_BYTES];
    logic sda_lo_q;
    int busy_len_q;

    always_ff @(posedge ref_clk_i) begin
        rsy1_q <= {req_tgl_q, write_protect_i};
        rsy2_q <= rsy1_q;
    end

    wire wp_s = rsy2_q[0];
    wire req_new = rsy2_q[1] ^ req_ack_q;
    wire tep_xfer_s xreq = xfer_q;
    // no take while reset holds: the payload may be stale
    wire take = req_new & ~busy_q & rst_n_i;
    wire is_load = (xreq.op == OP_LOAD) | (xreq.op == OP_LOAD_FIRST);
    wire [PAGE_BYTES-1:0] slot = PAGE_BYTES'(1) << xreq.addr[3:0];
    wire [3:0] widx = wr_cnt_q[3:0];
    wire in_burst = wr_cnt_q < CNT_W'(PAGE_BYTES);
    wire [7:0] waddr = {page_q, widx};
    wire mem_we = busy_q & in_burst & vld_q[widx]
                & wr_allowed(waddr, wp_s, prot_q);
    wire last = wr_cnt_q == CNT_W'(WR_CYCLES - 1);

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            busy_q <= 1'b0;
            wr_cnt_q <= '0;
            vld_q <= '0;
            page_q <= 4'h0;
            req_ack_q <= 1'b0;
            rd_q <= 8'h00;
        end else begin
            req_ack_q <= rsy2_q[1];
            if (busy_q) begin
                wr_cnt_q <= wr_cnt_q + CNT_W'(1);
                if (last) begin
                    busy_q <= 1'b0;
                    vld_q <= '0;
                end
            end else if (take) begin
                case (xreq.op)
                    OP_READ: rd_q <= mem_q[xreq.addr];
                    OP_LOAD_FIRST: begin
                        vld_q <= slot;
                        page_q <= xreq.addr[7:4];
                    end
                    OP_LOAD: begin
                        vld_q <= vld_q | slot;
                        page_q <= xreq.addr[7:4];
                    end
                    default: begin
                        busy_q <= 1'b1;
                        wr_cnt_q <= '0;
                        // protect command writes no array byte
                        if (xreq.op == OP_COMMIT_PROT) begin
                            vld_q <= '0;
                        end
                    end
                endcase
            end
        end
    end

    // later bytes of one page overwrite earlier ones
    always_ff @(posedge ref_clk_i) begin
        if (take & is_load) begin
            buf_q[xreq.addr[3:0]] <= xreq.data;
        end
    end

    // array contents survive reset
    always_ff @(posedge ref_clk_i) begin
        if (mem_we) begin
            mem_q[waddr] <= buf_q[widx];
        end
    end

    // protection bit: no reset, set only
    always_ff @(posedge ref_clk_i) begin
        if (take & (xreq.op == OP_COMMIT_PROT) & ~wp_s) begin
            prot_q <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            sda_lo_q <= 1'b0;
            busy_len_q <= 0;
        end else begin
            sda_lo_q <= 1'b0;
            busy_len_q <= busy_q ? busy_len_q + 1 : 0;
        end
    end

    assign sda_o = sda_lo_q;
    assign write_busy_o = busy_q;

    a_wr_cycle_len: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $fell(busy_q) |-> busy_len_q == int'(WR_CYCLES))
        else $error("write cycle length wrong");
    a_commit_busy: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        take && xreq.op inside {OP_COMMIT, OP_COMMIT_PROT}
        |=> busy_q ##1 busy_q)
        else $error("commit did not start write cycle");
    a_wp_blocks: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        busy_q && wp_s |-> !mem_we)
        else $error("array written with protect pin high");
    a_lower_lock: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        mem_we && prot_q |-> waddr[7])
        else $error("locked lower half written");
    a_prot_sticky: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        prot_q |=> prot_q)
        else $error("protection bit cleared");
    a_prot_wp_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        take && xreq.op == OP_COMMIT_PROT && wp_s && !prot_q
        |=> !prot_q)
        else $error("protection programmed with pin high");
endmodule : tep_core
`default_nettype wire

// >>> pkg/tep_pkg.sv
// package: constants and types of the two-wire eeprom core
`default_nettype none
package tep_pkg;
    localparam int ARRAY_BYTES = 256;
    localparam int PAGE_BYTES = 16;
    localparam logic [3:0] TYPE_MEM = 4'hA;
    localparam logic [3:0] TYPE_PROT = 4'h6;
    localparam logic [3:0] ACK_BIT = 4'h8;
    localparam logic [7:0] DUMMY_READ = 8'hFF;
    localparam logic PROT_INIT = 1'b0;
    localparam longint WRITE_CYCLE_TIME_NS = 5000000;
    localparam longint REF_CLK_PERIOD_NS = 25;
    // longest time: rounded down
    localparam int WR_CYCLE_CNT = int'(WRITE_CYCLE_TIME_NS / REF_CLK_PERIOD_NS);

    typedef enum logic [2:0] {
        OP_READ = 3'h0,
        OP_LOAD_FIRST = 3'h1,
        OP_LOAD = 3'h2,
        OP_COMMIT = 3'h3,
        OP_COMMIT_PROT = 3'h4
    } tep_op_e;

    typedef struct packed {
        tep_op_e op;
        logic [7:0] addr;
        logic [7:0] data;
    } tep_xfer_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_DEV = 3'h1,
        ST_WADDR = 3'h3,
        ST_WDATA = 3'h2,
        ST_RDATA = 3'h6,
        ST_WAIT = 3'h4
    } tep_state_e;
endpackage : tep_pkg
`default_nettype wire

// >>> tb/tb.sv
// self-checking bench for the two-wire eeprom core
`default_nettype none
module tb
    import tep_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WR_SIM = 1200;
    localparam int POLLS = 4;
    localparam logic [2:0] CS = 3'h5;
    localparam int LIMIT = 99000;
    logic ref_clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst_n = 1'b0;
    logic wp = 1'b0;
    logic scl;
    logic ctl_sda;
    logic dev_sda;
    logic dev_oe;
    logic busy;
    wire logic sda_line = ctl_sda & ~(dev_oe & ~dev_sda);
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;
    always #12.5 ref_clk = ~ref_clk;
    always #16 link_clk = ~link_clk;
    tep_core #(.WR_CYCLES(WR_SIM)) i_tep_core (
        .ref_clk_i(ref_clk), .rst_n_i(rst_n), .link_clk_i(link_clk),
        .scl_i(scl), .sda_i(sda_line), .sda_o(dev_sda),
        .sda_oe_o(dev_oe), .write_protect_i(wp),
        .chip_select_straps_i(CS), .write_busy_o(busy)
    );
    tep_ctl_model i_tep_ctl_model (
        .ref_clk_i(ref_clk), .sda_line_i(sda_line),
        .scl_o(scl), .sda_o(ctl_sda)
    );
    // ==========================================================
    // compare and bus helpers
    task automatic conclude();
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude
    task automatic chk1(input string what, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %b seen %b", what, e, g);
        end
    endtask : chk1
    task automatic chk8(input string what, input logic [7:0] e,
                        input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask : chk8
    task automatic do_reset(input int n);
        rst_n = 1'b0;
        repeat (n) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (20) @(negedge ref_clk);
    endtask : do_reset
    task automatic dev(input logic [3:0] ty, input logic [2:0] cs,
                       input logic rd, output logic ack);
        i_tep_ctl_model.start();
        i_tep_ctl_model.wbyte({ty, cs, rd}, ack);
    endtask : dev
    // polls inside the write cycle must go unanswered
    task automatic wait_cycle();
        logic k;
        repeat (20) @(negedge ref_clk);
        chk1("busy", 1'b1, busy);
        dev(TYPE_MEM, CS, 1'b0, k);
        chk1("poll ack", 1'b0, k);
        i_tep_ctl_model.stop();
        for (int n = 0; n < 2 * WR_SIM && busy !== 1'b0; n++) begin
            @(negedge ref_clk);
        end
        chk1("busy end", 1'b0, busy);
        // retry polls until answered or out of attempts
        for (int n = 0; n < POLLS && k !== 1'b1; n++) begin
            dev(TYPE_MEM, CS, 1'b0, k);
            i_tep_ctl_model.stop();
        end
        chk1("poll retry ack", 1'b1, k);
        repeat (20) @(negedge ref_clk);
    endtask : wait_cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic k;
        dev(TYPE_MEM, CS, 1'b0, k);
        chk1("wr dev ack", 1'b1, k);
        i_tep_ctl_model.wbyte(a, k);
        chk1("wr addr ack", 1'b1, k);
        i_tep_ctl_model.wbyte(d, k);
        chk1("wr data ack", 1'b1, k);
        i_tep_ctl_model.stop();
        wait_cycle();
    endtask : wr
    task automatic rd_at(input logic [7:0] a);
        logic k;
        dev(TYPE_MEM, CS, 1'b0, k);
        i_tep_ctl_model.wbyte(a, k);
        dev(TYPE_MEM, CS, 1'b1, k);
        chk1("rd dev ack", 1'b1, k);
    endtask : rd_at
    task automatic rd_chk(input logic more, input logic [7:0] e);
        logic [7:0] b;
        i_tep_ctl_model.rbyte(more, b);
        chk8("read data", e, b);
    endtask : rd_chk
    task automatic prot_cmd(input logic exp_ack);
        logic k;
        dev(TYPE_PROT, CS, 1'b0, k);
        chk1("prot ack", exp_ack, k);
        if (exp_ack) begin
            i_tep_ctl_model.wbyte(8'h00, k);
            i_tep_ctl_model.wbyte(8'h00, k);
        end
        i_tep_ctl_model.stop();
        if (exp_ack) wait_cycle();
    endtask : prot_cmd
    task automatic prot_status(input logic exp_ack);
        logic k;
        dev(TYPE_PROT, CS, 1'b1, k);
        chk1("status ack", exp_ack, k);
        if (exp_ack) rd_chk(1'b0, DUMMY_READ);
        i_tep_ctl_model.stop();
    endtask : prot_status
    // ==========================================================
    // scenarios
    task automatic t_select();
        logic k;
        dev(TYPE_MEM, CS ^ 3'h1, 1'b0, k);
        chk1("strap mismatch ack", 1'b0, k);
        i_tep_ctl_model.stop();
        $display("test select done");
    endtask : t_select
    task automatic t_reads();
        logic k;
        wr(8'hFF, 8'hC3);
        wr(8'h00, 8'h3C);
        rd_at(8'hFF);
        rd_chk(1'b0, 8'hC3);
        i_tep_ctl_model.stop();
        dev(TYPE_MEM, CS, 1'b1, k);
        chk1("current ack", 1'b1, k);
        rd_chk(1'b0, 8'h3C);
        i_tep_ctl_model.stop();
        $display("test reads done");
    endtask : t_reads
    // 17 bytes from 2Fh: wraps in page, last overwrites the first
    task automatic t_page();
        logic k;
        dev(TYPE_MEM, CS, 1'b0, k);
        i_tep_ctl_model.wbyte(8'h2F, k);
        for (int i = 0; i < 17; i++) begin
            i_tep_ctl_model.wbyte(8'h40 + 8'(i), k);
            chk1("page ack", 1'b1, k);
        end
        i_tep_ctl_model.stop();
        wait_cycle();
        rd_at(8'h2E);
        rd_chk(1'b1, 8'h4F);
        rd_chk(1'b0, 8'h50);
        i_tep_ctl_model.stop();
        $display("test page done");
    endtask : t_page
    task automatic t_protect();
        wp = 1'b1;
        repeat (4) @(negedge ref_clk);
        wr(8'hFF, 8'h11);
        rd_at(8'hFF);
        rd_chk(1'b0, 8'hC3);
        i_tep_ctl_model.stop();
        prot_cmd(1'b1);
        prot_status(1'b1);
        wp = 1'b0;
        repeat (4) @(negedge ref_clk);
        prot_cmd(1'b1);
        prot_status(1'b0);
        prot_cmd(1'b0);
        do_reset(8);
        prot_status(1'b0);
        wr(8'h00, 8'h99);
        wr(8'hFF, 8'h99);
        rd_at(8'hFF);
        rd_chk(1'b1, 8'h99);
        rd_chk(1'b0, 8'h3C);
        i_tep_ctl_model.stop();
        $display("test protect done");
    endtask : t_protect
    // ==========================================================
    // sequence and run limit
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            err_total++;
            $display("[FAIL] run length expected below %0d", LIMIT);
            conclude();
        end
    end
    initial begin
        do_reset(5);
        t_select();
        t_reads();
        t_page();
        t_protect();
        conclude();
    end
endmodule : tb
`default_nettype wire

// >>> tb/tep_ctl_model.sv
// bus controller model driving the eeprom core
`default_nettype none
module tep_ctl_model (
    input wire logic ref_clk_i,
    input wire logic sda_line_i,
    output var logic scl_o,
    output var logic sda_o
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int QTR = 25;
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic qtr();
        repeat (QTR) @(negedge ref_clk_i);
    endtask : qtr
    // also serves as repeated start and poll attempt
    task automatic start();
        sda_o = 1'b1;
        qtr();
        scl_o = 1'b1;
        qtr();
        sda_o = 1'b0;
        qtr();
        scl_o = 1'b0;
        qtr();
    endtask : start
    task automatic stop();
        sda_o = 1'b0;
        qtr();
        scl_o = 1'b1;
        qtr();
        sda_o = 1'b1;
        qtr();
    endtask : stop
    // data set in clock low, line sampled mid high
    task automatic clk_bit(input logic b, output logic s);
        sda_o = b;
        qtr();
        scl_o = 1'b1;
        qtr();
        s = sda_line_i;
        qtr();
        scl_o = 1'b0;
        qtr();
    endtask : clk_bit
    // msb first, ack slot on ninth clock
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(b[i], s);
        end
        clk_bit(1'b1, s);
        ack = ~s;
    endtask : wbyte
    // ack asks for more, no ack ends the read
    task automatic rbyte(input logic more, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, b[i]);
        end
        clk_bit(~more, s);
    endtask : rbyte
endmodule : tep_ctl_model
`default_nettype wire
